// ==== wake_regs.svh ====
`ifndef WAKE_REGS_SVH
`define WAKE_REGS_SVH

`define CSR_MAGIC_EN 1
`define CSR_FRAME_EN 2
`define CSR_MAGIC_RX 4
`define CSR_FRAME_RX 5
`define CSR_IRQ_EN 8
`define CSR_PME_EN 9

`define FILT_WORDS 8
`define FILT_CMD_WORD 4
`define FILT_OFF_WORD 5
`define FILT_CRC_WORD 6
`define FILT_CMD_EN 0
`define FILT_CMD_MCAST 3
`define MASK_SPAN 9'h01f

`define CRC_POLY 16'h8005
`define CRC_INIT 16'hffff

`define ADDR_BYTES 9'h006
`define HDR_BYTES 9'h00c
`define SYNC_BYTES 3'h6
`define ADDR_LAST 3'h5
`define REP_LAST 4'hf
`define IDX_MAX 9'h1ff

`endif

// ==== wake_pkg.sv ====
package wake_pkg;
    typedef logic [7:0] byte_t;
    typedef logic [15:0] crc_t;
    typedef enum logic [2:0]
    {
        HUNT = 3'b001,
        ADDR = 3'b010,
        DONE = 3'b100
    } magic_state_e;
endpackage : wake_pkg

// ==== filter_cfg_if.sv ====
interface filter_cfg_if;
    logic wr;
    logic [31:0] wdata;
    logic [7:0][31:0] words;
    modport store (input wr, input wdata, output words);
    modport user (output wr, output wdata, input words);
endinterface : filter_cfg_if

// ==== filter_table.sv ====
`include "wake_regs.svh"
module filter_table (
    input wire logic i_clk,
    input wire logic i_rst_n,
    filter_cfg_if.store cfg
);
    import wake_pkg::*;

    logic [2:0] ptr_reg;
    logic [7:0][31:0] words_reg;

    assign cfg.words = words_reg;

    // each write lands in the next word; any reset rewinds to filter 0 mask
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            ptr_reg <= 3'h0;
        end
        else if (cfg.wr)
        begin
            ptr_reg <= ptr_reg + 3'h1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            words_reg <= '0;
        end
        else if (cfg.wr)
        begin
            words_reg[ptr_reg] <= cfg.wdata;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    ptr_step_a: assert property (
        cfg.wr |=> ptr_reg == 3'($past(ptr_reg) + 3'h1)
            && words_reg[$past(ptr_reg)] == $past(cfg.wdata))
        else $error("filter word not loaded at write pointer");
endmodule : filter_table

// ==== wake_detect.sv ====
`include "wake_regs.svh"
module wake_detect (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_filt_wr,
    input wire logic [31:0] i_filt_wdata,
    input wire logic i_csr_wr,
    input wire logic [31:0] i_csr_wdata,
    output logic [31:0] o_csr_rdata,
    input wire logic [47:0] i_station_addr,
    input wire logic i_rx_valid,
    input wire logic i_rx_sof,
    input wire logic i_rx_eof,
    input wire wake_pkg::byte_t i_rx_data,
    output logic o_rx_normal_en,
    output logic o_host_irq,
    output logic o_power_event
);
    import wake_pkg::*;

    function automatic crc_t crc16_byte(input crc_t c, input byte_t d);
        crc_t r;
        r = c;
        for (int b = 7; b >= 0; b--)
        begin
            if (r[15] ^ d[b])
            begin
                r = {r[14:0], 1'b0} ^ `CRC_POLY;
            end
            else
            begin
                r = {r[14:0], 1'b0};
            end
        end
        return r;
    endfunction : crc16_byte

    // byte k of the station address in wire order, first byte in bits 7:0
    function automatic byte_t addr_byte(input logic [47:0] a,
                                        input logic [2:0] k);
        return a[{k, 3'b000} +: 8];
    endfunction : addr_byte

    filter_cfg_if cfg ();

    assign cfg.wr = i_filt_wr;
    assign cfg.wdata = i_filt_wdata;

    filter_table u_table (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .cfg(cfg)
    );

    logic magic_en_reg;
    logic frame_en_reg;
    logic irq_en_reg;
    logic pme_en_reg;
    logic magic_flag_reg;
    logic frame_flag_reg;
    logic irq_reg;
    logic pme_reg;

    logic [3:0][30:0] mask;
    logic [3:0][3:0] cmd;
    logic [3:0][7:0] offs;
    logic [3:0][15:0] exp_crc;
    logic [3:0] take;
    logic [3:0] hit;
    crc_t [3:0] crc_reg;
    crc_t [3:0] crc_next;

    logic [8:0] idx_reg;
    logic [8:0] cur_idx;
    logic mcast_reg;
    logic da_ok_reg;
    logic eval_reg;
    logic frame_hit;
    logic magic_ok;

    magic_state_e state_reg;
    logic [2:0] ff_cnt_reg;
    logic [2:0] pos_reg;
    logic [3:0] rep_reg;
    logic magic_hit_reg;
    logic in_body;
    logic addr_match;
    logic is_ff;
    logic last_rep;

    // filter field decode from the eight loaded words
    always_comb
    begin
        for (int f = 0; f < 4; f++)
        begin
            mask[f] = cfg.words[f][30:0];
            cmd[f] = cfg.words[`FILT_CMD_WORD][8*f +: 4];
            offs[f] = cfg.words[`FILT_OFF_WORD][8*f +: 8];
            exp_crc[f] = cfg.words[`FILT_CRC_WORD + f/2][16*(f%2) +: 16];
        end
    end

    // byte index within the frame; the start byte is index 0
    assign cur_idx = i_rx_sof ? 9'h000 : idx_reg;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            idx_reg <= 9'h000;
        end
        else if (i_rx_valid)
        begin
            idx_reg <= (cur_idx == `IDX_MAX) ? cur_idx : cur_idx + 9'h001;
        end
    end

    // per filter: is this byte inside the masked window
    always_comb
    begin
        logic [8:0] rel;
        crc_t base;
        rel = 9'h000;
        base = `CRC_INIT;
        for (int f = 0; f < 4; f++)
        begin
            rel = cur_idx - {1'b0, offs[f]};
            take[f] = (cur_idx >= {1'b0, offs[f]}) && (rel < `MASK_SPAN)
                && mask[f][rel[4:0]];
            base = i_rx_sof ? `CRC_INIT : crc_reg[f];
            crc_next[f] = take[f] ? crc16_byte(base, i_rx_data) : base;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            crc_reg <= {4{`CRC_INIT}};
        end
        else if (i_rx_valid)
        begin
            crc_reg <= crc_next;
        end
    end

    // destination checks: group bit and station address match
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            mcast_reg <= 1'b0;
            da_ok_reg <= 1'b0;
        end
        else if (i_rx_valid)
        begin
            if (cur_idx == 9'h000)
            begin
                mcast_reg <= i_rx_data[0];
                da_ok_reg <= i_rx_data == addr_byte(i_station_addr, 3'h0);
            end
            else if (cur_idx < `ADDR_BYTES)
            begin
                da_ok_reg <= da_ok_reg
                    && i_rx_data == addr_byte(i_station_addr, cur_idx[2:0]);
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            eval_reg <= 1'b0;
        end
        else
        begin
            eval_reg <= i_rx_valid && i_rx_eof;
        end
    end

    // filter verdict, one cycle after the last byte
    always_comb
    begin
        for (int f = 0; f < 4; f++)
        begin
            hit[f] = eval_reg && cmd[f][`FILT_CMD_EN]
                && (cmd[f][`FILT_CMD_MCAST] ? mcast_reg
                    : (!mcast_reg && da_ok_reg))
                && crc_reg[f] == exp_crc[f];
        end
    end

    assign frame_hit = |hit && frame_en_reg;

    // broadcast carries the group bit, so it is covered by mcast_reg
    assign magic_ok = da_ok_reg || mcast_reg;

    // magic packet scanner, only past both address fields
    assign in_body = !i_rx_sof && cur_idx >= `HDR_BYTES;
    assign is_ff = i_rx_data == 8'hff;
    assign addr_match = i_rx_data == addr_byte(i_station_addr, pos_reg);
    assign last_rep = in_body && state_reg == ADDR && addr_match
        && pos_reg == `ADDR_LAST && rep_reg == `REP_LAST;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            state_reg <= HUNT;
            ff_cnt_reg <= 3'h0;
            pos_reg <= 3'h0;
            rep_reg <= 4'h0;
        end
        else if (i_rx_valid && i_rx_sof)
        begin
            state_reg <= HUNT;
            ff_cnt_reg <= 3'h0;
            pos_reg <= 3'h0;
            rep_reg <= 4'h0;
        end
        else if (i_rx_valid && in_body)
        begin
            case (state_reg)
                HUNT:
                begin
                    if (is_ff)
                    begin
                        if (ff_cnt_reg != `SYNC_BYTES)
                        begin
                            ff_cnt_reg <= ff_cnt_reg + 3'h1;
                        end
                    end
                    else if (ff_cnt_reg == `SYNC_BYTES && addr_match)
                    begin
                        state_reg <= ADDR;
                        pos_reg <= 3'h1;
                        rep_reg <= 4'h0;
                        ff_cnt_reg <= 3'h0;
                    end
                    else
                    begin
                        ff_cnt_reg <= 3'h0;
                    end
                end
                ADDR:
                begin
                    if (!addr_match)
                    begin
                        state_reg <= HUNT;
                        ff_cnt_reg <= is_ff ? 3'h1 : 3'h0;
                        pos_reg <= 3'h0;
                    end
                    else if (pos_reg == `ADDR_LAST)
                    begin
                        pos_reg <= 3'h0;
                        if (rep_reg == `REP_LAST)
                        begin
                            state_reg <= DONE;
                        end
                        else
                        begin
                            rep_reg <= rep_reg + 4'h1;
                        end
                    end
                    else
                    begin
                        pos_reg <= pos_reg + 3'h1;
                    end
                end
                DONE:
                begin
                    state_reg <= DONE;
                end
                default:
                begin
                    state_reg <= HUNT;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            magic_hit_reg <= 1'b0;
        end
        else
        begin
            magic_hit_reg <= i_rx_valid && last_rep;
        end
    end

    // control bits written by software
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            magic_en_reg <= 1'b0;
            frame_en_reg <= 1'b0;
            irq_en_reg <= 1'b0;
            pme_en_reg <= 1'b0;
        end
        else if (i_csr_wr)
        begin
            magic_en_reg <= i_csr_wdata[`CSR_MAGIC_EN];
            frame_en_reg <= i_csr_wdata[`CSR_FRAME_EN];
            irq_en_reg <= i_csr_wdata[`CSR_IRQ_EN];
            pme_en_reg <= i_csr_wdata[`CSR_PME_EN];
        end
    end

    // sticky flags, write one to clear; a new event wins over the clear
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            magic_flag_reg <= 1'b0;
            frame_flag_reg <= 1'b0;
        end
        else
        begin
            magic_flag_reg <= (magic_hit_reg && magic_en_reg && magic_ok)
                || (magic_flag_reg
                    && !(i_csr_wr && i_csr_wdata[`CSR_MAGIC_RX]));
            frame_flag_reg <= frame_hit
                || (frame_flag_reg
                    && !(i_csr_wr && i_csr_wdata[`CSR_FRAME_RX]));
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            irq_reg <= 1'b0;
            pme_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= irq_en_reg
                && (magic_flag_reg || frame_flag_reg);
            pme_reg <= pme_en_reg
                && (magic_flag_reg || frame_flag_reg);
        end
    end

    assign o_host_irq = irq_reg;
    assign o_power_event = pme_reg;

    // normal reception follows the enables with no delay
    assign o_rx_normal_en = !(magic_en_reg || frame_en_reg);

    always_comb
    begin
        o_csr_rdata = 32'h0000_0000;
        o_csr_rdata[`CSR_MAGIC_EN] = magic_en_reg;
        o_csr_rdata[`CSR_FRAME_EN] = frame_en_reg;
        o_csr_rdata[`CSR_MAGIC_RX] = magic_flag_reg;
        o_csr_rdata[`CSR_FRAME_RX] = frame_flag_reg;
        o_csr_rdata[`CSR_IRQ_EN] = irq_en_reg;
        o_csr_rdata[`CSR_PME_EN] = pme_en_reg;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence sync_seen_s;
        state_reg == HUNT && ff_cnt_reg == `SYNC_BYTES;
    endsequence

    sequence final_copy_s;
        i_rx_valid && last_rep;
    endsequence

    sequence broken_run_s;
        i_rx_valid && in_body && state_reg == ADDR && !addr_match;
    endsequence

    resume_rx_a: assert property (
        $fell(magic_en_reg) && !frame_en_reg |-> o_rx_normal_en)
        else $error("reception not resumed after magic enable clear");

    magic_flag_a: assert property (
        magic_hit_reg && magic_en_reg && magic_ok |=> magic_flag_reg)
        else $error("magic received flag not set");

    filter_off_a: assert property (
        eval_reg |-> (hit & ~{cmd[3][0], cmd[2][0], cmd[1][0], cmd[0][0]})
            == 4'h0)
        else $error("disabled filter matched");

    addr_type_a: assert property (
        hit[0] |-> cmd[0][`FILT_CMD_MCAST] == mcast_reg)
        else $error("filter matched wrong address type");

    crc_equal_a: assert property (
        hit[1] |-> crc_reg[1] == exp_crc[1] && eval_reg)
        else $error("filter matched with unequal crc");

    frame_flag_a: assert property (
        frame_hit |=> frame_flag_reg ##1 !frame_en_reg || frame_flag_reg
            || $past(i_csr_wr))
        else $error("frame wake received not set");

    sixteen_copies_a: assert property (
        final_copy_s |=> magic_hit_reg && state_reg == DONE)
        else $error("magic packet not declared after last copy");

    sync_first_a: assert property (
        state_reg == HUNT ##1 state_reg == ADDR
            |-> $past(ff_cnt_reg) == `SYNC_BYTES)
        else $error("address run entered without sync");

    run_restart_a: assert property (
        broken_run_s and !(i_rx_sof) |=> state_reg == HUNT
            && pos_reg == 3'h0)
        else $error("broken run did not restart search");

    sync_entry_a: assert property (
        sync_seen_s ##0 (i_rx_valid && in_body && !is_ff && addr_match)
            |=> state_reg == ADDR && pos_reg == 3'h1)
        else $error("address run not taken after sync");

    irq_out_a: assert property (
        irq_en_reg && magic_flag_reg ##1 irq_en_reg |-> o_host_irq)
        else $error("host interrupt not raised");
endmodule : wake_detect

// ==== rx_frame_source.sv ====
module rx_frame_source (
    input wire logic i_clk,
    output logic o_rx_valid,
    output logic o_rx_sof,
    output logic o_rx_eof,
    output wake_pkg::byte_t o_rx_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import wake_pkg::*;

    initial
    begin
        o_rx_valid = 1'b0;
        o_rx_sof = 1'b0;
        o_rx_eof = 1'b0;
        o_rx_data = 8'h5a;
    end

    // one byte per cycle, sof on the first and eof on the last
    task automatic send(input byte_t f[$]);
        for (int i = 0; i < f.size(); i++)
        begin
            @(posedge i_clk);
            o_rx_valid <= 1'b1;
            o_rx_sof <= (i == 0);
            o_rx_eof <= (i == f.size() - 1);
            o_rx_data <= f[i];
        end
        @(posedge i_clk);
        o_rx_valid <= 1'b0;
        o_rx_sof <= 1'b0;
        o_rx_eof <= 1'b0;
        // released data does not keep the last byte
        o_rx_data <= ~o_rx_data;
    endtask : send
endmodule : rx_frame_source

// ==== tb_wake_detect.sv ====
module tb_wake_detect;
    timeunit 1ns;
    timeprecision 1ps;
    import wake_pkg::*;

    localparam logic [47:0] STA = 48'h55_44_33_22_11_00;
    logic i_clk, i_rst_n, i_filt_wr, i_csr_wr;
    logic [31:0] i_filt_wdata, i_csr_wdata, o_csr_rdata;
    logic rx_valid, rx_sof, rx_eof;
    logic o_rx_normal_en, o_host_irq, o_power_event;
    byte_t rx_data;
    byte_t fr[$];
    crc_t good;
    int error_cnt = 0;
    int compares = 0;

    wake_detect wake_detect_inst (
        .i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_filt_wr(i_filt_wr), .i_filt_wdata(i_filt_wdata),
        .i_csr_wr(i_csr_wr), .i_csr_wdata(i_csr_wdata),
        .o_csr_rdata(o_csr_rdata), .i_station_addr(STA),
        .i_rx_valid(rx_valid), .i_rx_sof(rx_sof),
        .i_rx_eof(rx_eof), .i_rx_data(rx_data),
        .o_rx_normal_en(o_rx_normal_en),
        .o_host_irq(o_host_irq), .o_power_event(o_power_event)
    );

    rx_frame_source rx_frame_source_inst (
        .i_clk(i_clk), .o_rx_valid(rx_valid), .o_rx_sof(rx_sof),
        .o_rx_eof(rx_eof), .o_rx_data(rx_data)
    );

    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    task automatic check(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic csr_wr(logic [31:0] d);
        @(posedge i_clk);
        i_csr_wr <= 1'b1;
        i_csr_wdata <= d;
        @(posedge i_clk);
        i_csr_wr <= 1'b0;
        // let the write edge settle before anyone reads the result
        #1;
    endtask : csr_wr

    function automatic crc_t crc_ref(input byte_t b[$]);
        crc_t c;
        logic fb;
        c = 16'hffff;
        foreach (b[i])
        begin
            for (int k = 7; k >= 0; k--)
            begin
                fb = c[15] ^ b[i][k];
                c = {c[14:0], 1'b0};
                if (fb)
                begin
                    c = c ^ 16'h8005;
                end
            end
        end
        return c;
    endfunction : crc_ref

    // destination then a fixed source address
    task automatic hdr(logic [47:0] d);
        fr = {};
        for (int k = 0; k < 6; k++)
            fr.push_back(d[8*k+:8]);
        for (int k = 0; k < 6; k++)
            fr.push_back(8'ha0 + 8'(k));
    endtask : hdr

    task automatic sync_reps(int n);
        repeat (6) fr.push_back(8'hff);
        repeat (n)
            for (int k = 0; k < 6; k++)
                fr.push_back(STA[8*k+:8]);
    endtask : sync_reps

    task automatic magic_case(string n, logic [47:0] d, int nrep,
                              bit again, bit ex, logic [31:0] cfg);
        csr_wr(cfg);
        check({n, " normal"}, 32'h0, 32'(o_rx_normal_en));
        hdr(d);
        fr.push_back(8'h12);
        sync_reps(nrep);
        fr.push_back(8'h3c);
        if (again)
            sync_reps(16);
        fr.push_back(8'h77);
        rx_frame_source_inst.send(fr);
        repeat (4) @(posedge i_clk);
        check({n, " flag"}, 32'(ex), 32'(o_csr_rdata[4]));
        check({n, " irq"}, 32'(ex & cfg[8]), 32'(o_host_irq));
        check({n, " pme"}, 32'(ex & cfg[9]), 32'(o_power_event));
        csr_wr(32'h0000_0010);
        check({n, " clear"}, 32'h0, o_csr_rdata);
        check({n, " resume"}, 32'h1, 32'(o_rx_normal_en));
        $display("test %s done", n);
    endtask : magic_case

    // only filter f set up: offset 13, bytes 13 and 15, mask bit 31 set too
    task automatic filt_case(string n, int f, logic [3:0] cmd, crc_t crc,
                             logic [47:0] d, bit ex);
        logic [31:0] w[8];
        w = '{default: 32'h0};
        w[f] = 32'h8000_0005;
        w[4][8*f +: 4] = cmd;
        w[5][8*f +: 8] = 8'h0d;
        w[6 + f/2][16*(f%2) +: 16] = crc;
        foreach (w[i])
        begin
            @(posedge i_clk);
            i_filt_wr <= 1'b1;
            i_filt_wdata <= w[i];
        end
        @(posedge i_clk);
        i_filt_wr <= 1'b0;
        csr_wr(32'h0000_0104);
        check({n, " normal"}, 32'h0, 32'(o_rx_normal_en));
        hdr(d);
        for (int i = 12; i < 20; i++)
            fr.push_back(8'h40 + 8'(i));
        rx_frame_source_inst.send(fr);
        repeat (4) @(posedge i_clk);
        check({n, " csr"}, ex ? 32'h124 : 32'h104, o_csr_rdata);
        check({n, " irq"}, 32'(ex), 32'(o_host_irq));
        csr_wr(32'h0000_0020);
        check({n, " resume"}, 32'h1, 32'(o_rx_normal_en));
        $display("test %s done", n);
    endtask : filt_case

    initial
    begin
        repeat (20000) @(posedge i_clk);
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        i_rst_n = 1'b0;
        i_filt_wr = 1'b0;
        i_filt_wdata = 32'h0;
        i_csr_wr = 1'b0;
        i_csr_wdata = 32'h0;
        good = crc_ref({8'h4d, 8'h4f});
        repeat (5) @(posedge i_clk);
        i_rst_n <= 1'b1;
        @(posedge i_clk);
        #1;
        check("reset csr", 32'h0, o_csr_rdata);
        check("reset normal", 32'h1, 32'(o_rx_normal_en));
        check("reset irq", 32'h0, 32'({o_host_irq, o_power_event}));
        magic_case("magic_ucast", STA, 16, 0, 1, 32'h302);
        magic_case("magic_bcast", '1, 16, 0, 1, 32'h102);
        magic_case("magic_other", STA ^ 2, 16, 0, 0, 32'h302);
        magic_case("magic_mcast", STA ^ 1, 16, 0, 1, 32'h202);
        magic_case("magic_broken", STA, 15, 0, 0, 32'h302);
        magic_case("magic_restart", STA, 15, 1, 1, 32'h302);
        filt_case("filt_ucast", 0, 4'h1, good, STA, 1);
        filt_case("filt_uc1", 1, 4'h1, good, STA, 1);
        filt_case("filt_badcrc", 1, 4'h1, good ^ 1, STA, 0);
        filt_case("filt_off", 2, 4'h0, good, STA, 0);
        filt_case("filt_mc_uc", 3, 4'h9, good, STA, 0);
        filt_case("filt_mc", 3, 4'h9, good, STA ^ 1, 1);
        filt_case("filt_mc2", 2, 4'h9, good, STA ^ 1, 1);
        filt_case("filt_uc_mc", 2, 4'h1, good, STA ^ 1, 0);
        report_and_stop();
    end
endmodule : tb_wake_detect
